// file: src/sd_sync_pkg.sv
// Package for the sigma-delta timing and filter synchronisation block.
// Assumes a single master clock domain; no software-visible registers.
package sd_sync_pkg;

  // ********************************************************************
  // Rates and widths
  // ********************************************************************
  localparam int unsigned REF_DIV       = 256;  // Reference sampling divider
  localparam int unsigned PRESC_W       = 8;    // Counter width for REF_DIV
  localparam int unsigned NOTCH_W       = 12;   // Notch select code width
  localparam int unsigned MOD_DIV_W     = 8;    // Modulator divider width
  localparam int unsigned CAL_W         = 4;    // Calibration cycle count width
  localparam int unsigned WORD_W        = 24;   // Result width
  localparam logic [7:0]  MOD_DIV_DFLT  = 8'h7F;   // Master clocks per modulator tick - 1
  localparam logic [11:0] NOTCH_DFLT    = 12'h180; // Modulator ticks per update - 1
  localparam logic [3:0]  CAL_CONV_DFLT = 4'h2;    // Updates consumed by a calibration - 1

  // ********************************************************************
  // Control state
  // ********************************************************************
  typedef enum logic [2:0] {
    ST_SETTLE = 3'b001,
    ST_RUN    = 3'b010,
    ST_CAL    = 3'b100
  } mode_t;

  typedef struct packed {
    logic [1:0]         sync_pipe;
    logic               sync_prev;
    logic [PRESC_W-1:0] ref_cnt;
    logic [7:0]         mod_cnt;
    logic [11:0]        notch_cnt;
    logic [3:0]         cal_cnt;
    mode_t              mode;
    logic [WORD_W-1:0]  accum;
    logic [WORD_W-1:0]  result;
    logic               ref_tick;
    logic               mod_tick;
    logic               update;
    logic               filt_rst;
    logic               cal_busy;
  } state_t;

endpackage

// file: src/sd_sync_ctrl.sv
// Timing and filter synchronisation control for a free-running converter.
// Assumes cal_cmd, notch_sel and mod_bit are synchronous to ref_clk; sync_n may not be.
`timescale 1ns/10ps

// Behaviour
// - Conversions run continuously after reset with no start command.
// - Result register updates at notch rate; it is readable at any time.
// - Reference sampled every 256 master clocks regardless of gain.
// - Reference and modulator rates are counted in master clock cycles; notch rate in modulator ticks, calibration time in windows.
// - Falling sync edge resets the digital filter to a known state.
// - Any calibration command resets the digital filter.
module sd_sync_ctrl #(
  parameter logic [7:0]  MOD_DIV  = sd_sync_pkg::MOD_DIV_DFLT,
  parameter logic [3:0]  CAL_CONV = sd_sync_pkg::CAL_CONV_DFLT
) (
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  input  wire logic        sync_n,
  input  wire logic        cal_cmd,
  input  wire logic [11:0] notch_sel,
  input  wire logic        mod_bit,
  output logic             ref_sample,
  output logic             mod_sample,
  output logic             result_update,
  output logic             filter_reset,
  output logic             cal_busy,
  output logic [23:0]      result
);

  // ********************************************************************
  // State registers
  // ********************************************************************
  sd_sync_pkg::state_t st;
  sd_sync_pkg::state_t next_st;
  logic                sync_fall;

  // ********************************************************************
  // Filter restart shared by sync and calibration
  // ********************************************************************
  // Tick cleared too, else a wrap on the restart cycle shortens the window
  function automatic sd_sync_pkg::state_t restart_filter(input sd_sync_pkg::state_t s);
    sd_sync_pkg::state_t r;
    r           = s;
    r.accum     = 24'h000000;
    r.notch_cnt = 12'h000;
    r.mod_cnt   = 8'h00;
    r.mod_tick  = 1'b0;
    r.update    = 1'b0;
    r.filt_rst  = 1'b1;
    return r;
  endfunction

  always_comb begin
    next_st = st;
    next_st.sync_pipe = {st.sync_pipe[0], sync_n};
    next_st.sync_prev = st.sync_pipe[1];
    sync_fall = st.sync_prev & ~st.sync_pipe[1];

    next_st.ref_cnt = st.ref_cnt + 8'h01;
    next_st.ref_tick = (st.ref_cnt == 8'(sd_sync_pkg::REF_DIV - 1));

    next_st.mod_tick = 1'b0;
    if (st.mod_cnt == MOD_DIV) begin
      next_st.mod_cnt = 8'h00;
      next_st.mod_tick = 1'b1;
    end else begin
      next_st.mod_cnt = st.mod_cnt + 8'h01;
    end

    next_st.update = 1'b0;
    next_st.filt_rst = 1'b0;
    if (st.mod_tick) begin
      next_st.accum = st.accum + {23'h000000, mod_bit};
      if (st.notch_cnt >= notch_sel) begin
        next_st.notch_cnt = 12'h000;
        next_st.accum = 24'h000000;
        if (st.mode == sd_sync_pkg::ST_CAL) begin
          if (st.cal_cnt == CAL_CONV) begin
            next_st.mode = sd_sync_pkg::ST_RUN;
          end else begin
            next_st.cal_cnt = st.cal_cnt + 4'h1;
          end
        end else begin
          next_st.result = st.accum;
          next_st.update = 1'b1;
          next_st.mode = sd_sync_pkg::ST_RUN;
        end
      end else begin
        next_st.notch_cnt = st.notch_cnt + 12'h001;
      end
    end

    // Calibration wins over sync since it also restarts its own count
    if (cal_cmd) begin
      next_st         = restart_filter(next_st);
      next_st.cal_cnt = 4'h0;
      next_st.mode    = sd_sync_pkg::ST_CAL;
    end else if (sync_fall) begin
      next_st      = restart_filter(next_st);
      next_st.mode = sd_sync_pkg::ST_SETTLE;
    end
    next_st.cal_busy = (next_st.mode == sd_sync_pkg::ST_CAL);
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      st <= '{sync_pipe: 2'h3, sync_prev: 1'b1, ref_cnt: 8'h00, mod_cnt: 8'h00,
              notch_cnt: 12'h000, cal_cnt: 4'h0, mode: sd_sync_pkg::ST_SETTLE,
              accum: 24'h000000, result: 24'h000000, ref_tick: 1'b0,
              mod_tick: 1'b0, update: 1'b0, filt_rst: 1'b0, cal_busy: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  // ********************************************************************
  // Outputs, all straight from flops
  // ********************************************************************
  assign ref_sample    = st.ref_tick;
  assign mod_sample    = st.mod_tick;
  assign result_update = st.update;
  assign filter_reset  = st.filt_rst;
  assign cal_busy      = st.cal_busy;
  assign result        = st.result;

  // ********************************************************************
  // Checks
  // ********************************************************************
  property p_ref_period;
    @(posedge ref_clk) disable iff (!resetn)
      st.ref_tick |-> ##256 st.ref_tick;
  endproperty
  a_ref_period: assert property (p_ref_period) else $error("ref period wrong");

  property p_sync_reset;
    @(posedge ref_clk) disable iff (!resetn)
      $fell(st.sync_pipe[1]) && !cal_cmd |=> st.filt_rst && st.notch_cnt == 12'h000;
  endproperty
  a_sync_reset: assert property (p_sync_reset) else $error("sync did not reset");

  property p_cal_reset;
    @(posedge ref_clk) disable iff (!resetn)
      cal_cmd |=> st.filt_rst && st.cal_busy && st.accum == 24'h000000;
  endproperty
  a_cal_reset: assert property (p_cal_reset) else $error("cal did not reset");

  property p_sync_delay;
    @(posedge ref_clk) disable iff (!resetn)
      $fell(sync_n) ##1 !sync_n [*2] ##0 !cal_cmd |=> st.filt_rst;
  endproperty
  a_sync_delay: assert property (p_sync_delay) else $error("sync path wrong");

  property p_result_hold;
    @(posedge ref_clk) disable iff (!resetn)
      !st.update |-> st.result == $past(st.result);
  endproperty
  a_result_hold: assert property (p_result_hold) else $error("result moved");

  property p_mod_free;
    @(posedge ref_clk) disable iff (!resetn)
      !cal_cmd && !sync_fall && st.mod_cnt == MOD_DIV |=> st.mod_tick;
  endproperty
  a_mod_free: assert property (p_mod_free) else $error("modulator stalled");

  property p_no_update_cal;
    @(posedge ref_clk) disable iff (!resetn)
      st.cal_busy |-> !st.update;
  endproperty
  a_no_update_cal: assert property (p_no_update_cal) else $error("update in cal");

  property p_ref_free;
    @(posedge ref_clk) disable iff (!resetn)
      st.ref_cnt == 8'(sd_sync_pkg::REF_DIV - 1) |=> st.ref_tick;
  endproperty
  a_ref_free: assert property (p_ref_free) else $error("ref strobe missed");

  property p_ref_gap;
    @(posedge ref_clk) disable iff (!resetn)
      st.ref_tick |=> !st.ref_tick;
  endproperty
  a_ref_gap: assert property (p_ref_gap) else $error("ref strobe too long");

  property p_mod_bound;
    @(posedge ref_clk) disable iff (!resetn)
      st.mod_cnt <= MOD_DIV;
  endproperty
  a_mod_bound: assert property (p_mod_bound) else $error("modulator count out of range");

  property p_update_take;
    @(posedge ref_clk) disable iff (!resetn)
      st.mod_tick && st.notch_cnt >= notch_sel && st.mode != sd_sync_pkg::ST_CAL &&
      !cal_cmd && !sync_fall |=> st.update && st.result == $past(st.accum);
  endproperty
  a_update_take: assert property (p_update_take) else $error("window end missed");

  property p_filt_pulse;
    @(posedge ref_clk) disable iff (!resetn)
      st.filt_rst && !cal_cmd && !sync_fall |=> !st.filt_rst;
  endproperty
  a_filt_pulse: assert property (p_filt_pulse) else $error("filter reset stuck");

  property p_restart_clean;
    @(posedge ref_clk) disable iff (!resetn)
      st.filt_rst |-> st.mod_cnt == 8'h00 && !st.mod_tick && st.notch_cnt == 12'h000 &&
      st.accum == 24'h000000;
  endproperty
  a_restart_clean: assert property (p_restart_clean) else $error("restart left state");

  property p_sync_mode;
    @(posedge ref_clk) disable iff (!resetn)
      sync_fall && !cal_cmd |=> !st.cal_busy;
  endproperty
  a_sync_mode: assert property (p_sync_mode) else $error("sync left calibration on");

endmodule

// file: tb/sd_host_model.sv
// Host model driving the sync line, calibration command and modulator bit.
// Assumes its tasks are called at a falling edge of ref_clk.
`timescale 1ns/10ps
module sd_host_model (
  input  wire logic ref_clk,
  output logic      sync_n,
  output logic      cal_cmd,
  output logic      mod_bit
);
  initial begin
    sync_n  = 1'b1;
    cal_cmd = 1'b0;
    mod_bit = 1'b1;
  end
  task automatic pulse_sync();
    sync_n = 1'b0;
    repeat (4) @(negedge ref_clk);
    sync_n = 1'b1;
  endtask
  task automatic pulse_cal();
    cal_cmd = 1'b1;
    @(negedge ref_clk);
    cal_cmd = 1'b0;
  endtask
  // Modulator level, so window sums are not constant
  task automatic set_bit(input logic b);
    mod_bit = b;
  endtask
endmodule

// file: tb/sd_sync_ctrl_bench.sv
// Bench for the sync control block with a host model on the far side.
// Assumes a small divider and notch so windows are 16 clocks long.
`timescale 1ns/10ps
module sd_sync_ctrl_bench;
  logic        ref_clk, resetn, sync_n, cal_cmd, mod_bit;
  logic        ref_sample, mod_sample, result_update, filter_reset, cal_busy;
  logic [23:0] result;
  int          errors, checks_done;
  wire  [4:0]  ev = {cal_busy, filter_reset, result_update, mod_sample, ref_sample};
  sd_host_model i_host (.ref_clk(ref_clk), .sync_n(sync_n), .cal_cmd(cal_cmd),
    .mod_bit(mod_bit));
  sd_sync_ctrl #(.MOD_DIV(8'h03), .CAL_CONV(4'h1)) i_dut (.ref_clk(ref_clk),
    .resetn(resetn), .sync_n(sync_n), .cal_cmd(cal_cmd), .notch_sel(12'h003),
    .mod_bit(mod_bit), .ref_sample(ref_sample), .mod_sample(mod_sample),
    .result_update(result_update), .filter_reset(filter_reset),
    .cal_busy(cal_busy), .result(result));
  // ******************************
  // Shared tasks
  // ******************************
  task automatic check(input string name, input logic [23:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Bounded wait so a dead strobe cannot hang the run
  task automatic wait_ev(input int k, output int n);
    n = 0;
    do begin
      @(posedge ref_clk);
      #1 n++;
    end while (ev[k] !== 1'b1 && n < 2000);
    // Limit ran out counts as a mismatch
    if (ev[k] !== 1'b1) errors++;
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic t_rates();
    int n;
    wait_ev(0, n);
    wait_ev(0, n);
    check("ref_period", n, 256);
    wait_ev(1, n);
    wait_ev(1, n);
    check("mod_period", n, 4);
    $display("test rates done");
  endtask
  task automatic t_free();
    int n;
    wait_ev(2, n);
    wait_ev(2, n);
    check("upd_period", n, 16);
    // Window end tick's bit is dropped as the sum clears, so notch_sel ticks count
    check("result", result, 24'h000003);
    @(negedge ref_clk);
    i_host.set_bit(1'b0);
    wait_ev(2, n);
    check("result_zero", result, 24'h000000);
    @(negedge ref_clk);
    i_host.set_bit(1'b1);
    $display("test free run done");
  endtask
  task automatic t_sync();
    int n;
    @(negedge ref_clk);
    fork i_host.pulse_sync(); join_none
    wait_ev(3, n);
    check("sync_delay", n, 3);
    wait_ev(2, n);
    // Restart edge, a full window of ticks, then the closing edge
    check("sync_upd", n, 17);
    check("sync_result", result, 24'h000003);
    $display("test sync done");
  endtask
  task automatic t_cal();
    int n, u;
    @(negedge ref_clk);
    fork i_host.pulse_cal(); join_none
    wait_ev(3, n);
    check("cal_reset", n, 1);
    u = 0;
    n = 0;
    // Busy for two windows of four ticks; no update may slip through
    while (cal_busy === 1'b1 && n < 200) begin
      @(posedge ref_clk);
      #1 n++;
      u += int'(result_update);
    end
    check("cal_upd", u, 0);
    check("cal_len", n, 33);
    wait_ev(2, n);
    check("cal_first_upd", n, 16);
    check("cal_result", result, 24'h000003);
    $display("test cal done");
  endtask
  task automatic t_reset();
    int n;
    @(negedge ref_clk);
    resetn = 1'b0;
    #1;
    check("rst_strobes", 24'(ev), 24'h000000);
    check("rst_result", result, 24'h000000);
    repeat (2) @(negedge ref_clk);
    resetn = 1'b1;
    wait_ev(2, n);
    check("rst_upd", n, 17);
    check("rst_result2", result, 24'h000003);
    $display("test reset done");
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  initial begin
    #500000;
    errors++;
    final_report();
  end
  initial begin
    errors = 0;
    checks_done = 0;
    resetn = 1'b0;
    repeat (6) @(negedge ref_clk);
    resetn = 1'b1;
    t_rates();
    t_free();
    t_sync();
    t_cal();
    t_reset();
    final_report();
  end
endmodule
